// ==== shared/xta_pkg.sv ====
// Constants, types and states for the X.21 call state and ready-for-data alignment block.
package xta_pkg;

    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned GUARD_MS     = 100;
    localparam int unsigned GUARD_CYCLES = CLK_HZ / 1000 * GUARD_MS;
    localparam logic [4:0]  PATTERN_BITS = 5'h18;
    localparam logic [4:0]  RFD_BITS     = 5'h10;
    localparam logic [15:0] CALLING_ALIGN_TIMEOUT_BITS = 16'h1F40;
    localparam logic [15:0] CALLED_ALIGN_TIMEOUT_BITS  = 16'h1F40;

    typedef enum logic [2:0] {
        MSG_NONE,
        MSG_CONNECT,
        MSG_CONN_ACK,
        MSG_RELEASE,
        MSG_REL_COMPLETE,
        MSG_DISCONNECT
    } xta_msg_code_t;

    typedef struct packed {
        logic          valid;
        xta_msg_code_t code;
    } xta_msg_t;

    typedef enum logic [3:0] {
        ST_READY,
        ST_OUTGOING,
        ST_INCOMING,
        ST_WAIT_ACK,
        ST_DELIVER,
        ST_CONN_PROG,
        ST_ECHO,
        ST_RFD_WAIT,
        ST_RFD,
        ST_DATA,
        ST_CLEAR_CONF,
        ST_CLEAR_IND,
        ST_MP_CLEAR,
        ST_DCE_READY
    } xta_state_t;

endpackage : xta_pkg

// ==== verilog/xta_call_align.sv ====
// Terminal adaptor call state mapping and 64 kbit/s ready-for-data alignment.
`timescale 1ns/1ps
`default_nettype none
module xta_call_align
    import xta_pkg::*;
#(
    parameter int unsigned GUARD_CYC = GUARD_CYCLES
) (
    input  wire logic     ref_clk,
    input  wire logic     reset_n,
    input  wire logic     clk_en,
    input  wire logic     bit_tick,
    input  wire logic     octet_tick,
    input  wire logic     byte_timing_en,
    input  wire logic     opt_guard_en,
    input  wire logic     early_switch,
    input  wire logic     dte_t,
    input  wire logic     dte_c,
    input  wire logic     b_rx,
    input  wire logic     call_placed,
    input  wire logic     call_offered,
    input  wire logic     dce_info_busy,
    input  wire xta_msg_t net_msg,
    input  wire logic     msg_out_ready,
    output logic          dce_r,
    output logic          dce_i,
    output logic          b_tx,
    output logic          b_through,
    output logic          call_ref_free,
    output xta_msg_t      msg_out
);

    function automatic logic dte_is(input logic t, input logic c, input logic want_t, input logic want_c);
        dte_is = (t == want_t) && (c == want_c);
    endfunction : dte_is

    xta_state_t    state;
    xta_state_t    next_state;
    logic          next_push;
    xta_msg_code_t next_code;
    logic [1:0]    t_sync;
    logic [1:0]    c_sync;
    logic          dte_t_s;
    logic          dte_c_s;
    logic          tick;
    logic          calling;
    logic [4:0]    ones_cnt;
    logic [4:0]    bit_cnt;
    logic [15:0]   tmo_cnt;
    logic [21:0]   guard_cnt;
    logic          guard_done;
    logic          detected;
    logic          timed_out;
    logic          net_disc;
    logic          in_call;
    xta_msg_t      tail;
    logic          buf_ready;
    logic          pop;

    assign dte_t_s    = t_sync[1];
    assign dte_c_s    = c_sync[1];
    assign tick       = clk_en && bit_tick;
    assign detected   = (ones_cnt == PATTERN_BITS) && (calling ? guard_done : 1'b1);
    assign timed_out  = tmo_cnt == (calling ? CALLING_ALIGN_TIMEOUT_BITS : CALLED_ALIGN_TIMEOUT_BITS);
    assign net_disc   = net_msg.valid && (net_msg.code == MSG_DISCONNECT);
    assign in_call    = (state != ST_READY) && (state != ST_CLEAR_CONF) && (state != ST_CLEAR_IND)
                        && (state != ST_MP_CLEAR) && (state != ST_DCE_READY);
    assign buf_ready  = !tail.valid;
    assign pop        = msg_out.valid && msg_out_ready;

    // Terminal pins are asynchronous to the network timing.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            t_sync <= 2'h3;
            c_sync <= 2'h0;
        end else if (clk_en) begin
            t_sync <= {t_sync[0], dte_t};
            c_sync <= {c_sync[0], dte_c};
        end
    end

    // A message is only emitted while the buffer has room, so back-pressure holds the state.
    always_comb begin
        next_state = state;
        next_push  = 1'b0;
        next_code  = MSG_NONE;
        if (in_call && net_disc && buf_ready) begin
            next_state = ST_CLEAR_IND;
            next_push  = 1'b1;
            next_code  = MSG_RELEASE;
        end else if (in_call && state != ST_INCOMING && dte_is(dte_t_s, dte_c_s, 1'b0, 1'b0) && buf_ready) begin
            next_state = ST_CLEAR_CONF;
            next_push  = 1'b1;
            next_code  = MSG_DISCONNECT;
        end else begin
            case (state)
                ST_READY: begin
                    if (call_placed) begin
                        next_state = ST_OUTGOING;
                    end else if (call_offered) begin
                        next_state = ST_INCOMING;
                    end
                end
                ST_OUTGOING: begin
                    if (net_msg.valid && net_msg.code == MSG_CONNECT) begin
                        next_state = ST_DELIVER;
                    end
                end
                ST_INCOMING: begin
                    if (dte_is(dte_t_s, dte_c_s, 1'b1, 1'b1) && buf_ready) begin
                        next_state = ST_WAIT_ACK;
                        next_push  = 1'b1;
                        next_code  = MSG_CONNECT;
                    end
                end
                ST_WAIT_ACK: begin
                    if (net_msg.valid && net_msg.code == MSG_CONN_ACK) begin
                        next_state = ST_DELIVER;
                    end else if (net_msg.valid && net_msg.code == MSG_RELEASE) begin
                        next_state = ST_MP_CLEAR;
                    end
                end
                ST_DELIVER: begin
                    if (!dce_info_busy) begin
                        next_state = ST_CONN_PROG;
                    end
                end
                ST_CONN_PROG: begin
                    if (calling && detected) begin
                        next_state = ST_ECHO;
                    end else if (detected || timed_out || early_switch) begin
                        next_state = ST_RFD_WAIT;
                    end
                end
                ST_ECHO: begin
                    // Echo of the pattern for 24 bits.
                    if (tick && bit_cnt == PATTERN_BITS - 5'h01) begin
                        next_state = ST_RFD_WAIT;
                    end
                end
                ST_RFD_WAIT: begin
                    // With byte timing, indication only turns on at an octet boundary.
                    // Without byte timing it still waits for a bit boundary, so ready for data spans whole bits.
                    if (byte_timing_en ? (clk_en && octet_tick) : tick) begin
                        next_state = ST_RFD;
                    end
                end
                ST_RFD: begin
                    // Ready for data holds 16 bit times.
                    if (tick && bit_cnt == RFD_BITS - 5'h01) begin
                        next_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    next_state = ST_DATA;
                end
                ST_CLEAR_CONF: begin
                    if (net_msg.valid && net_msg.code == MSG_RELEASE && buf_ready) begin
                        next_state = ST_DCE_READY;
                        next_push  = 1'b1;
                        next_code  = MSG_REL_COMPLETE;
                    end
                end
                ST_CLEAR_IND: begin
                    if (net_msg.valid && net_msg.code == MSG_REL_COMPLETE) begin
                        next_state = ST_DCE_READY;
                    end
                end
                ST_MP_CLEAR: begin
                    // Wait for clear confirmation, then release complete.
                    if (dte_is(dte_t_s, dte_c_s, 1'b0, 1'b0) && buf_ready) begin
                        next_state = ST_DCE_READY;
                        next_push  = 1'b1;
                        next_code  = MSG_REL_COMPLETE;
                    end
                end
                ST_DCE_READY: begin
                    // Terminal back to ready returns the interface to idle.
                    if (dte_is(dte_t_s, dte_c_s, 1'b1, 1'b0)) begin
                        next_state = ST_READY;
                    end
                end
                default: begin
                    next_state = ST_READY;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_READY;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            calling <= 1'b0;
        end else if (clk_en && state == ST_READY) begin
            calling <= call_placed;
        end
    end

    // Consecutive ones counter restarts on a zero.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ones_cnt <= 5'h00;
        end else if (state != ST_CONN_PROG) begin
            if (clk_en) begin
                ones_cnt <= 5'h00;
            end
        end else if (tick) begin
            if (!b_rx) begin
                ones_cnt <= 5'h00;
            end else if (ones_cnt != PATTERN_BITS) begin
                ones_cnt <= ones_cnt + 5'h01;
            end
        end
    end

    // Optional guard delays the caller's search.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_cnt  <= 22'h00_0000;
            guard_done <= 1'b0;
        end else if (clk_en) begin
            if (state == ST_OUTGOING || state == ST_READY) begin
                guard_cnt  <= 22'h00_0000;
                guard_done <= !opt_guard_en;
            end else if (!guard_done) begin
                guard_cnt  <= guard_cnt + 22'h00_0001;
                guard_done <= guard_cnt == 22'(GUARD_CYC - 1);
            end
        end
    end

    // The timeout counts bit times in connection in progress only.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tmo_cnt <= 16'h0000;
        end else if (clk_en && state != ST_CONN_PROG) begin
            tmo_cnt <= 16'h0000;
        end else if (tick && !timed_out) begin
            tmo_cnt <= tmo_cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt <= 5'h00;
        end else if (clk_en && next_state != state) begin
            bit_cnt <= 5'h00;
        end else if (tick) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Outputs follow the next state, so they line up with the state register.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dce_r     <= 1'b1;
            dce_i     <= 1'b0;
            b_tx      <= 1'b1;
            b_through <= 1'b0;
        end else if (clk_en) begin
            // Idle lines are one and OFF.
            dce_r     <= !(next_state == ST_CLEAR_CONF || next_state == ST_CLEAR_IND || next_state == ST_MP_CLEAR);
            dce_i     <= next_state == ST_RFD;
            b_through <= next_state == ST_DATA;
            // Ones are the default pattern outside data, delivery and the caller's connection in progress.
            b_tx      <= 1'b1;
            if (next_state == ST_DATA) begin
                // Data transfer stays transparent until clearing.
                dce_r <= b_rx;
                b_tx  <= dte_t_s;
            end else if (next_state == ST_DELIVER || (next_state == ST_CONN_PROG && calling)) begin
                // Zeros while DCE information is delivered.
                b_tx <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            call_ref_free <= 1'b0;
        end else if (clk_en) begin
            call_ref_free <= next_push && next_code == MSG_REL_COMPLETE;
        end
    end

    // Two-entry buffer toward the D-channel; a stalled receiver loses no message.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            msg_out <= '0;
            tail    <= '0;
        end else if (clk_en) begin
            if (next_push && !pop) begin
                if (!msg_out.valid) begin
                    msg_out <= '{valid: 1'b1, code: next_code};
                end else begin
                    tail <= '{valid: 1'b1, code: next_code};
                end
            end else if (pop && !next_push) begin
                msg_out <= tail;
                tail    <= '0;
            end else if (pop && next_push) begin
                if (tail.valid) begin
                    msg_out <= tail;
                    tail    <= '{valid: 1'b1, code: next_code};
                end else begin
                    msg_out <= '{valid: 1'b1, code: next_code};
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_rfd_last;
        state == ST_RFD && next_state == ST_DATA && clk_en;
    endsequence

    sequence s_accept;
        state == ST_INCOMING && next_state == ST_WAIT_ACK && clk_en;
    endsequence

    chk_idle_lines: assert property (state == ST_READY |-> dce_r && !dce_i)
        else $error("Idle lines not one and OFF.");
    chk_call_accept: assert property (s_accept |=> msg_out.valid || tail.valid)
        else $error("Call accept queued no message.");
    chk_conn_prog: assert property (state == ST_CONN_PROG |-> dce_r && !dce_i && !b_through)
        else $error("Connection in progress lines wrong.");
    chk_clear_conf: assert property (state == ST_CLEAR_CONF |-> !dce_r && !dce_i && !b_through)
        else $error("Clear confirmation lines wrong.");
    chk_net_clear: assert property (in_call && net_disc && buf_ready && clk_en |=> state == ST_CLEAR_IND && !dce_r)
        else $error("Network clear not indicated.");
    chk_zeros_deliver: assert property (state == ST_DELIVER |-> !b_tx)
        else $error("B-channel not zero during delivery.");
    chk_rfd_length: assert property (s_rfd_last |-> bit_cnt == RFD_BITS - 5'h01 && tick)
        else $error("Ready for data length wrong.");
    chk_octet_edge: assert property ($rose(dce_i) && $past(byte_timing_en) |-> $past(octet_tick))
        else $error("Indication rose off an octet boundary.");
    chk_ones_restart: assert property (tick && !b_rx |=> ones_cnt == 5'h00)
        else $error("Ones counter not restarted.");
    chk_data_pass: assert property (clk_en && state == ST_DATA && next_state == ST_DATA |=> b_tx == $past(dte_t_s))
        else $error("Data path not transparent.");

endmodule : xta_call_align
`default_nettype wire

// ==== verification/xta_far_model.sv ====
// Far side of the B-channel: network bit timing and the distant adaptor's bit stream.
`timescale 1ns/1ps
`default_nettype none
module xta_far_model #(
    parameter int unsigned BIT_DIV = 8
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] b_mode,
    input  wire logic       data_bit,
    output logic            bit_tick,
    output logic            octet_tick,
    output logic            b_rx
);
    int unsigned div_cnt;
    logic [2:0]  bit_cnt;

    // Bit timing runs faster than 64 kbit/s so that alignment fits a short run.
    always @(negedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt = 0;
            bit_cnt = 3'h0;
            bit_tick <= 1'b0;
            octet_tick <= 1'b0;
            b_rx <= 1'b0;
        end else begin
            div_cnt = (div_cnt + 1) % BIT_DIV;
            bit_tick <= (div_cnt == 0);
            octet_tick <= (div_cnt == 0) && (bit_cnt == 3'h7);
            if (div_cnt == 0) begin
                bit_cnt = bit_cnt + 3'h1;
                b_rx <= (b_mode == 2'd1) || ((b_mode == 2'd2) && data_bit);
            end
        end
    end
endmodule : xta_far_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking testbench for the call state and ready-for-data alignment block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import xta_pkg::*;
    localparam int unsigned BIT_DIV = 8;
    logic ref_clk, reset_n, clk_en, bit_tick, octet_tick, byte_timing_en, opt_guard_en;
    logic early_switch, dte_t, dte_c, b_rx, call_placed, call_offered, dce_info_busy;
    logic msg_out_ready, data_bit, dce_r, dce_i, b_tx, b_through, call_ref_free;
    logic [1:0]    b_mode;
    logic [15:0]   lfsr;
    xta_msg_t      net_msg, msg_out;
    xta_msg_code_t got[$];
    int            num_errors, checks_done, ref_frees, k;

    xta_call_align #(.GUARD_CYC(20)) i_xta_call_align (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .bit_tick(bit_tick),
        .octet_tick(octet_tick), .byte_timing_en(byte_timing_en), .opt_guard_en(opt_guard_en),
        .early_switch(early_switch), .dte_t(dte_t), .dte_c(dte_c), .b_rx(b_rx),
        .call_placed(call_placed), .call_offered(call_offered), .dce_info_busy(dce_info_busy),
        .net_msg(net_msg), .msg_out_ready(msg_out_ready), .dce_r(dce_r), .dce_i(dce_i),
        .b_tx(b_tx), .b_through(b_through), .call_ref_free(call_ref_free), .msg_out(msg_out)
    );

    xta_far_model #(.BIT_DIV(BIT_DIV)) i_xta_far_model (
        .ref_clk(ref_clk), .reset_n(reset_n), .b_mode(b_mode), .data_bit(data_bit),
        .bit_tick(bit_tick), .octet_tick(octet_tick), .b_rx(b_rx)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Random stalls of the message receiver exercise the two-entry buffer.
    always @(negedge ref_clk) begin
        lfsr <= lfsr_next(lfsr);
        msg_out_ready <= lfsr[0] | lfsr[2];
    end

    always @(posedge ref_clk) begin
        if (reset_n && msg_out.valid && msg_out_ready) got.push_back(msg_out.code);
        if (reset_n && call_ref_free) ref_frees++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick

    task automatic set_dte(input logic t, input logic c);
        dte_t = t;
        dte_c = c;
        tick(4);
    endtask : set_dte

    task automatic offer(input logic placed);
        call_placed = placed;
        call_offered = !placed;
        tick(1);
        call_placed = 1'b0;
        call_offered = 1'b0;
        tick(1);
    endtask : offer

    task automatic net(input xta_msg_code_t c);
        net_msg = '{valid: 1'b1, code: c};
        tick(1);
        net_msg = '0;
        tick(2);
    endtask : net

    task automatic expect_msg(input xta_msg_code_t c);
        int n;
        for (n = 0; n < 200 && got.size() == 0; n++) tick(1);
        if (got.size() == 0) check(8'h00, 8'(c));
        else check(8'(got.pop_front()), 8'(c));
    endtask : expect_msg

    task automatic rfd_phase(input int min_pre, input int min_ones);
        int n, pre, ones, j;
        logic up;
        n = 0; pre = 0; ones = 0; up = 1'b0;
        for (j = 0; j < 3000 && b_through !== 1'b1; j++) begin
            @(negedge ref_clk);
            if (dce_i && !up && byte_timing_en) check(8'(octet_tick), 8'h01);
            up = up | dce_i;
            if (bit_tick && !up) pre++;
            if (bit_tick && !up && b_tx) ones++;
            if (bit_tick && dce_i) n++;
        end
        check(8'(pre >= min_pre), 8'h01);
        check(8'(ones >= min_ones), 8'h01);
        check(8'(n), 8'h10);
        check(8'(b_through), 8'h01);
    endtask : rfd_phase

    task automatic data_phase();
        b_mode = 2'd2;
        dte_c = 1'b1;
        for (k = 0; k < 8; k++) begin
            dte_t = lfsr[3];
            data_bit = lfsr[5];
            tick(2 * BIT_DIV);
            check(8'(b_tx), 8'(dte_t));
            check(8'(dce_r), 8'(b_rx));
        end
        b_mode = 2'd0;
    endtask : data_phase

    task automatic net_clear();
        net(MSG_DISCONNECT);
        expect_msg(MSG_RELEASE);
        check(8'({dce_r, dce_i, b_through}), 8'h00);
        set_dte(1'b0, 1'b0);
        net(MSG_REL_COMPLETE);
        check(8'({dce_r, dce_i, b_through}), 8'h04);
        set_dte(1'b1, 1'b0);
        check(8'({dce_r, dce_i, b_tx}), 8'h05);
    endtask : net_clear

    task automatic complete_run();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #2_000_000;
        num_errors++;
        complete_run();
    end

    initial begin
        lfsr = 16'h000B;
        {reset_n, byte_timing_en, opt_guard_en, early_switch, call_placed, call_offered} = '0;
        {dce_info_busy, data_bit, dte_c, b_mode, net_msg} = '0;
        {clk_en, dte_t} = 2'b11;
        tick(20);
        check(8'({dce_r, dce_i, b_tx, b_through}), 8'h0A);
        check(8'(msg_out), 8'h00);
        reset_n = 1'b1;
        tick(4);
        // Called side with byte timing and a broken run of ones.
        byte_timing_en = 1'b1;
        offer(1'b0);
        set_dte(1'b1, 1'b1);
        expect_msg(MSG_CONNECT);
        dce_info_busy = 1'b1;
        net(MSG_CONN_ACK);
        tick(10);
        check(8'({dce_i, b_tx}), 8'h00);
        dce_info_busy = 1'b0;
        tick(4);
        check(8'({dce_r, dce_i, b_tx}), 8'h05);
        b_mode = 2'd1;
        tick(20 * BIT_DIV);
        b_mode = 2'd0;
        tick(2 * BIT_DIV);
        b_mode = 2'd1;
        rfd_phase(24, 24);
        data_phase();
        net_clear();
        $display("test called_align done");
        // Calling side with guard delay, echo and terminal clearing.
        byte_timing_en = 1'b0;
        opt_guard_en = 1'b1;
        offer(1'b1);
        net(MSG_CONNECT);
        tick(4);
        check(8'(b_tx), 8'h00);
        b_mode = 2'd1;
        rfd_phase(48, 24);
        data_phase();
        set_dte(1'b0, 1'b0);
        expect_msg(MSG_DISCONNECT);
        check(8'({dce_r, dce_i, b_through}), 8'h00);
        k = ref_frees;
        net(MSG_RELEASE);
        expect_msg(MSG_REL_COMPLETE);
        check(8'(ref_frees - k), 8'h01);
        check(8'({dce_r, dce_i}), 8'h02);
        set_dte(1'b1, 1'b0);
        $display("test calling_align done");
        // Unselected adaptor in a multiterminal setup.
        offer(1'b0);
        set_dte(1'b1, 1'b1);
        expect_msg(MSG_CONNECT);
        net(MSG_RELEASE);
        check(8'({dce_r, dce_i}), 8'h00);
        set_dte(1'b0, 1'b0);
        expect_msg(MSG_REL_COMPLETE);
        check(8'(dce_r), 8'h01);
        set_dte(1'b1, 1'b0);
        $display("test multipoint done");
        // Early switch-through without waiting for the pattern.
        early_switch = 1'b1;
        offer(1'b0);
        set_dte(1'b1, 1'b1);
        expect_msg(MSG_CONNECT);
        net(MSG_CONN_ACK);
        rfd_phase(0, 0);
        early_switch = 1'b0;
        net_clear();
        $display("test early_switch done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
